// *** design/pwm_host_pkg.sv ***
// Constants, register map and sequencer states of the PWM update controller
package pwm_host_pkg;
	// Compare value width of the timer
	localparam int CMP_W = 16;
	// Register byte offsets on the AXI4-Lite side
	localparam logic [4:0] OFF_PERIOD = 5'h00;
	localparam logic [4:0] OFF_CH1 = 5'h04;
	localparam logic [4:0] OFF_CH2 = 5'h08;
	localparam logic [4:0] OFF_CH3 = 5'h0c;
	localparam logic [4:0] OFF_CTRL = 5'h10;
	localparam logic [4:0] OFF_STATUS = 5'h14;
	// Device compare register selects, also staging memory index
	localparam logic [1:0] SEL_PERIOD = 2'h0;
	localparam logic [1:0] SEL_CH1 = 2'h1;
	localparam logic [1:0] SEL_CH2 = 2'h2;
	localparam logic [1:0] SEL_CH3 = 2'h3;
	// Control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_GO_BIT = 1;
	localparam int CTRL_PER_BIT = 2;
	localparam int CTRL_DUTY23_BIT = 3;
	// Status field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WAIT_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_RANGE_BIT = 3;
	localparam int ST_RUN_BIT = 4;
	localparam int ST_CH1_SEEN_BIT = 5;
	localparam int ST_PER_SEEN_BIT = 6;
	// Values after reset
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Read pipeline stages
	localparam logic [1:0] RD_IDLE = 2'h0;
	localparam logic [1:0] RD_ADDR = 2'h1;
	localparam logic [1:0] RD_DATA = 2'h2;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Update sequencer
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_PERIOD = 3'b001,
		SEQ_CH2 = 3'b010,
		SEQ_CH3 = 3'b011,
		SEQ_CH1 = 3'b100,
		SEQ_WAIT = 3'b101
	} seq_state_t;
endpackage : pwm_host_pkg

// *** design/pwm_update_host.sv ***
// Controller that stages PWM compare values and loads them into the timer in safe order
`timescale 1ns/1ps
module pwm_update_host #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Timer compare register write port
	output logic cmp_wr,
	output logic [1:0] cmp_sel,
	output logic [pwm_host_pkg::CMP_W-1:0] cmp_wdata,
	output logic count_enable,
	// Timer match interrupts
	input wire logic period_match_irq,
	input wire logic chan1_match_irq
);
	localparam int W = pwm_host_pkg::CMP_W;

	initial begin
		if (ADDR_W < 5 || ADDR_W > 32) $error("pwm_update_host: ADDR_W out of range");
	end

	// Register index and decode helpers
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a >> 5) == '0 && a[4:0] <= pwm_host_pkg::OFF_STATUS && a[1:0] == 2'h0;
	endfunction : mapped

	function automatic logic is_off(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		is_off = (a >> 5) == '0 && a[4:0] == off;
	endfunction : is_off

	function automatic logic [1:0] sel_of(input pwm_host_pkg::seq_state_t s);
		case (s)
			pwm_host_pkg::SEQ_PERIOD: sel_of = pwm_host_pkg::SEL_PERIOD;
			pwm_host_pkg::SEQ_CH2: sel_of = pwm_host_pkg::SEL_CH2;
			pwm_host_pkg::SEQ_CH3: sel_of = pwm_host_pkg::SEL_CH3;
			default: sel_of = pwm_host_pkg::SEL_CH1;
		endcase
	endfunction : sel_of

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic aw_got_q, w_got_q;
	logic [ADDR_W-1:0] awaddr_q, araddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] rd_ph_q;
	logic [3:0] ctrl_q;
	logic [W-1:0] period_q;
	logic refused_q, range_q, per_seen_q, ch1_seen_q, full_q, start_q, ph_q, duty23_q;
	logic cmp_wr_q, count_enable_q;
	logic [1:0] cmp_sel_q;
	logic [W-1:0] cmp_wdata_q;
	pwm_host_pkg::seq_state_t state_q;
	logic [W-1:0] seq_rdata, bus_rdata;

	// Write and read handshakes
	wire aw_hs = awvalid && awready_q;
	wire w_hs = wvalid && wready_q;
	wire ar_hs = arvalid && arready_q;
	wire do_wr = aw_got_q && w_got_q && !bvalid_q;
	wire wr_ok = do_wr && mapped(awaddr_q);
	wire stage_wr = wr_ok && awaddr_q[4:0] <= pwm_host_pkg::OFF_CH3;
	wire ctrl_wr = wr_ok && is_off(awaddr_q, pwm_host_pkg::OFF_CTRL) && wstrb_q[0];
	wire stat_wr = wr_ok && is_off(awaddr_q, pwm_host_pkg::OFF_STATUS) && wstrb_q[0];
	wire ctrl_dis = ctrl_wr && !wdata_q[pwm_host_pkg::CTRL_EN_BIT];
	wire ctrl_start = ctrl_wr && wdata_q[pwm_host_pkg::CTRL_EN_BIT] && !count_enable_q
		&& state_q == pwm_host_pkg::SEQ_IDLE;
	wire go = ctrl_wr && wdata_q[pwm_host_pkg::CTRL_EN_BIT] && wdata_q[pwm_host_pkg::CTRL_GO_BIT];
	wire go_accept = go && count_enable_q && state_q == pwm_host_pkg::SEQ_IDLE;
	wire per_ok = per_seen_q || (period_match_irq && !cmp_wr_q);
	wire ch1_ok = ch1_seen_q || (chan1_match_irq && !cmp_wr_q) || full_q;
	// Channel value past period plus one, widened so an all-ones period never wraps
	wire chan_over = stage_wr && awaddr_q[3:2] != pwm_host_pkg::SEL_PERIOD && wstrb_q[1:0] == 2'h3
		&& {1'b0, wdata_q[W-1:0]} > ({1'b0, period_q} + 17'h00001);

	// Staging memory: bus writes, sequencer and bus reads on separate ports
	stage_mem #(.WIDTH(W), .DEPTH(4), .AW(2)) u_stage (
		.aclk(aclk),
		.wr_en(stage_wr),
		.wr_addr(awaddr_q[3:2]),
		.wr_be(wstrb_q[1:0]),
		.wr_data(wdata_q[W-1:0]),
		.rd_addr_a(sel_of(state_q)),
		.rd_data_a(seq_rdata),
		.rd_addr_b(araddr_q[3:2]),
		.rd_data_b(bus_rdata)
	);

	// Write channel: address and data accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= pwm_host_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_hs) begin
				awaddr_q <= awaddr;
				aw_got_q <= 1'b1;
				awready_q <= 1'b0;
			end else if (!aw_got_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (w_hs) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				w_got_q <= 1'b1;
				wready_q <= 1'b0;
			end else if (!w_got_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
			if (do_wr) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? pwm_host_pkg::RESP_OKAY : pwm_host_pkg::RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read channel: two cycles for the registered memory read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			araddr_q <= '0;
			rd_ph_q <= pwm_host_pkg::RD_IDLE;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= pwm_host_pkg::RESP_OKAY;
		end else begin
			case (rd_ph_q)
				pwm_host_pkg::RD_IDLE: begin
					if (ar_hs) begin
						araddr_q <= araddr;
						arready_q <= 1'b0;
						rd_ph_q <= pwm_host_pkg::RD_ADDR;
					end else if (!rvalid_q) begin
						arready_q <= 1'b1;
					end
				end
				pwm_host_pkg::RD_ADDR: rd_ph_q <= pwm_host_pkg::RD_DATA;
				pwm_host_pkg::RD_DATA: begin
					rvalid_q <= 1'b1;
					rd_ph_q <= pwm_host_pkg::RD_IDLE;
					rresp_q <= mapped(araddr_q) ? pwm_host_pkg::RESP_OKAY : pwm_host_pkg::RESP_SLVERR;
					if (!mapped(araddr_q)) begin
						rdata_q <= 32'h0000_0000;
					end else if (is_off(araddr_q, pwm_host_pkg::OFF_CTRL)) begin
						rdata_q <= {28'h0000000, ctrl_q};
					end else if (is_off(araddr_q, pwm_host_pkg::OFF_STATUS)) begin
						rdata_q <= {25'h0000000, per_seen_q, ch1_seen_q, count_enable_q, range_q, refused_q,
							state_q == pwm_host_pkg::SEQ_WAIT, state_q != pwm_host_pkg::SEQ_IDLE};
					end else begin
						rdata_q <= {16'h0000, bus_rdata};
					end
				end
				default: rd_ph_q <= pwm_host_pkg::RD_IDLE;
			endcase
			if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Control register and period copy used for range checks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= pwm_host_pkg::CTRL_RESET;
			period_q <= pwm_host_pkg::CMP_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= {wdata_q[pwm_host_pkg::CTRL_DUTY23_BIT], wdata_q[pwm_host_pkg::CTRL_PER_BIT], 1'b0,
					wdata_q[pwm_host_pkg::CTRL_EN_BIT]};
			end
			if (stage_wr && awaddr_q[3:2] == pwm_host_pkg::SEL_PERIOD) begin
				if (wstrb_q[0]) period_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) period_q[15:8] <= wdata_q[15:8];
			end
		end
	end

	// Sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused_q <= 1'b0;
			range_q <= 1'b0;
		end else begin
			if (go && !go_accept) refused_q <= 1'b1;
			else if (stat_wr && wdata_q[pwm_host_pkg::ST_REFUSED_BIT]) refused_q <= 1'b0;
			if (chan_over) range_q <= 1'b1;
			else if (stat_wr && wdata_q[pwm_host_pkg::ST_RANGE_BIT]) range_q <= 1'b0;
		end
	end

	// Match pulses come a clock late; cleared as channel 1 goes out so no old match frees a wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_seen_q <= 1'b0;
			ch1_seen_q <= 1'b0;
		end else if ((state_q == pwm_host_pkg::SEQ_CH1 && ph_q) || (cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH1)) begin
			per_seen_q <= 1'b0;
			ch1_seen_q <= 1'b0;
		end else if (state_q == pwm_host_pkg::SEQ_WAIT) begin
			if (period_match_irq) per_seen_q <= 1'b1;
			if (chan1_match_irq) ch1_seen_q <= 1'b1;
		end
	end

	// Update sequencer: fetch a staged value, then write it to the timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= pwm_host_pkg::SEQ_IDLE;
			ph_q <= 1'b0;
			start_q <= 1'b0;
			duty23_q <= 1'b0;
			full_q <= 1'b0;
			cmp_wr_q <= 1'b0;
			cmp_sel_q <= pwm_host_pkg::SEL_PERIOD;
			cmp_wdata_q <= pwm_host_pkg::CMP_RESET;
			count_enable_q <= 1'b0;
		end else begin
			cmp_wr_q <= 1'b0;
			if (ctrl_dis) begin
				state_q <= pwm_host_pkg::SEQ_IDLE;
				ph_q <= 1'b0;
				count_enable_q <= 1'b0;
			end else begin
				case (state_q)
					pwm_host_pkg::SEQ_IDLE: begin
						if (ctrl_start) begin
							// All four loaded before enable, shadows take them at start
							start_q <= 1'b1;
							state_q <= pwm_host_pkg::SEQ_PERIOD;
						end else if (go_accept) begin
							start_q <= 1'b0;
							duty23_q <= wdata_q[pwm_host_pkg::CTRL_DUTY23_BIT];
							if (wdata_q[pwm_host_pkg::CTRL_PER_BIT]) state_q <= pwm_host_pkg::SEQ_PERIOD;
							else if (wdata_q[pwm_host_pkg::CTRL_DUTY23_BIT]) state_q <= pwm_host_pkg::SEQ_CH2;
							else state_q <= pwm_host_pkg::SEQ_CH1;
						end
					end
					pwm_host_pkg::SEQ_PERIOD, pwm_host_pkg::SEQ_CH2, pwm_host_pkg::SEQ_CH3,
					pwm_host_pkg::SEQ_CH1: begin
						ph_q <= !ph_q;
						if (ph_q) begin
							cmp_wr_q <= 1'b1;
							cmp_sel_q <= sel_of(state_q);
							cmp_wdata_q <= seq_rdata;
							case (state_q)
								pwm_host_pkg::SEQ_PERIOD: state_q <= (start_q || duty23_q) ? pwm_host_pkg::SEQ_CH2
									: pwm_host_pkg::SEQ_CH1;
								pwm_host_pkg::SEQ_CH2: state_q <= pwm_host_pkg::SEQ_CH3;
								pwm_host_pkg::SEQ_CH3: state_q <= pwm_host_pkg::SEQ_CH1;
								default: begin
									// A 100% channel 1 never matches, so only period match is awaited
									full_q <= {1'b0, seq_rdata} == ({1'b0, period_q} + 17'h00001);
									if (start_q) begin
										count_enable_q <= 1'b1;
										state_q <= pwm_host_pkg::SEQ_IDLE;
									end else begin
										state_q <= pwm_host_pkg::SEQ_WAIT;
									end
								end
							endcase
						end
					end
					pwm_host_pkg::SEQ_WAIT: begin
						// Zero duty fires both matches together, which also releases the wait
						if (per_ok && ch1_ok) state_q <= pwm_host_pkg::SEQ_IDLE;
					end
					default: state_q <= pwm_host_pkg::SEQ_IDLE;
				endcase
			end
		end
	end

	// Outputs straight from flops
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign cmp_wr = cmp_wr_q;
	assign cmp_sel = cmp_sel_q;
	assign cmp_wdata = cmp_wdata_q;
	assign count_enable = count_enable_q;

	// Checks on sequencing and the sticky range and refused flags
	AST_CH3_THEN_CH1: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH3) ##0 !ctrl_dis[*2] |=> (cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH1))
		else $error("channel 3 write not closed by channel 1");
	AST_PERIOD_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_PERIOD) ##0 !ctrl_dis[*2]
		|=> (cmp_wr_q && (cmp_sel_q == pwm_host_pkg::SEL_CH2 || cmp_sel_q == pwm_host_pkg::SEL_CH1)))
		else $error("period write not followed by channel write");
	AST_CH2_CH3: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH2) ##0 !ctrl_dis[*2] |=> (cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH3))
		else $error("channel 2 write not followed by channel 3");
	AST_QUIET_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == pwm_host_pkg::SEQ_WAIT && $past(state_q) == pwm_host_pkg::SEQ_WAIT) |-> !cmp_wr_q)
		else $error("compare written while waiting for period match");
	AST_CH1_ARMS_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH1 && $past(count_enable_q) && !$past(ctrl_dis))
		|-> state_q == pwm_host_pkg::SEQ_WAIT)
		else $error("channel 1 write did not start the wait");
	AST_LEAVE_ON_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == pwm_host_pkg::SEQ_IDLE && $past(state_q) == pwm_host_pkg::SEQ_WAIT && !$past(ctrl_dis))
		|-> $past(!cmp_wr_q && (per_seen_q || period_match_irq)))
		else $error("wait left before period match");
	AST_ENABLE_WITH_CH1: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(count_enable_q) |-> (cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH1))
		else $error("enable raised without the final channel 1 load");
	AST_START_SPAN: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_PERIOD && !count_enable_q) ##0 !ctrl_dis[*6] |=> count_enable_q)
		else $error("enable not raised six cycles after period load");
	AST_RANGE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		chan_over |=> range_q)
		else $error("out-of-range channel value not flagged");
	AST_REFUSE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !go_accept) |=> refused_q)
		else $error("refused update not flagged");
	COV_START: cover property (@(posedge aclk) disable iff (!aresetn) $rose(count_enable_q));
	COV_FULL_UPDATE: cover property (@(posedge aclk) disable iff (!aresetn)
		(cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_PERIOD && count_enable_q) ##2 (cmp_wr_q && cmp_sel_q == pwm_host_pkg::SEL_CH2));
	COV_WAIT_DONE: cover property (@(posedge aclk) disable iff (!aresetn)
		state_q == pwm_host_pkg::SEQ_WAIT ##1 state_q == pwm_host_pkg::SEQ_IDLE);
	COV_REFUSED: cover property (@(posedge aclk) disable iff (!aresetn) go && !go_accept);
endmodule : pwm_update_host

// *** design/stage_mem.sv ***
// Small staging memory: one byte-enabled write port, two registered read ports
`timescale 1ns/1ps
module stage_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	// Clock
	input wire logic aclk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH/8-1:0] wr_be,
	input wire logic [WIDTH-1:0] wr_data,
	// Read ports
	input wire logic [AW-1:0] rd_addr_a,
	output logic [WIDTH-1:0] rd_data_a,
	input wire logic [AW-1:0] rd_addr_b,
	output logic [WIDTH-1:0] rd_data_b
);
	logic [WIDTH-1:0] mem [DEPTH];

	initial begin
		if (WIDTH % 8 != 0 || DEPTH > (1 << AW)) $error("stage_mem: bad geometry");
	end

	// Byte lanes written separately so partial AXI strobes merge in place
	always_ff @(posedge aclk) begin
		for (int i = 0; i < WIDTH / 8; i++) begin
			if (wr_en && wr_be[i]) begin
				mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
			end
		end
	end

	// Registered reads
	always_ff @(posedge aclk) begin
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end
endmodule : stage_mem

// *** tb/tb_top.sv ***
// Testbench for the PWM update controller against the behavioural timer
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] A_PER = {3'h0, pwm_host_pkg::OFF_PERIOD};
	localparam logic [7:0] A_C1 = {3'h0, pwm_host_pkg::OFF_CH1};
	localparam logic [7:0] A_C2 = {3'h0, pwm_host_pkg::OFF_CH2};
	localparam logic [7:0] A_C3 = {3'h0, pwm_host_pkg::OFF_CH3};
	localparam logic [7:0] A_CTL = {3'h0, pwm_host_pkg::OFF_CTRL};
	localparam logic [7:0] A_ST = {3'h0, pwm_host_pkg::OFF_STATUS};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid;
	logic cmp_wr, count_enable, period_match_irq, chan1_match_irq, early_write;
	logic [1:0] cmp_sel;
	logic [15:0] cmp_wdata;
	logic [17:0] wq[$];
	int failures = 0;
	int n_compared = 0;
	always #25 aclk = ~aclk;
	pwm_update_host u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
		.wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
		.rvalid, .rready, .rdata, .rresp, .cmp_wr, .cmp_sel, .cmp_wdata, .count_enable,
		.period_match_irq, .chan1_match_irq);
	timer_model u_timer (.aclk, .aresetn, .cmp_wr, .cmp_sel, .cmp_wdata, .count_enable,
		.period_match_irq, .chan1_match_irq, .early_write);
	// Log of timer writes, sel above data
	always @(posedge aclk) if (cmp_wr === 1'b1) wq.push_back({cmp_sel, cmp_wdata});
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	// Bus tasks end one edge after release so no signal is set twice at once
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		rs = bresp;
		bready <= 1'b0;
		if (!bvalid) begin
			failures++;
			end_sim();
		end
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		dv = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (!rvalid) begin
			failures++;
			end_sim();
		end
		@(posedge aclk);
	endtask : axi_rd
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		logic [1:0] rs;
		axi_wr(a, dv, rs);
		check({30'h0, rs}, {30'h0, pwm_host_pkg::RESP_OKAY});
	endtask : wr
	// Polls busy and waiting bits; a long wait means a hung update
	task automatic wait_idle();
		logic [31:0] s;
		logic [1:0] rs;
		int n;
		n = 0;
		do begin
			axi_rd(A_ST, s, rs);
			n++;
		end while (s[1:0] !== 2'b00 && n < 100);
		if (n >= 100) begin
			failures++;
			end_sim();
		end
	endtask : wait_idle
	task automatic seq(input int n, input logic [17:0] e [4]);
		check(wq.size(), n);
		for (int i = 0; i < n && wq.size() > 0; i++) check({14'h0, wq.pop_front()}, {14'h0, e[i]});
		wq.delete();
	endtask : seq
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// Reset values and an unmapped place
		axi_rd(A_CTL, d, r);
		check(d, 32'h0);
		axi_rd(A_ST, d, r);
		check(d, 32'h0);
		axi_rd(8'h18, d, r);
		check({d[29:0], r}, {30'h0, pwm_host_pkg::RESP_SLVERR});
		axi_wr(8'h18, 32'h1, r);
		check({30'h0, r}, {30'h0, pwm_host_pkg::RESP_SLVERR});
		$display("done: registers");
		// Start with 0 and 100 percent channels
		wr(A_PER, 32'h9);
		wr(A_C1, 32'h4);
		wr(A_C2, 32'h0);
		wr(A_C3, 32'ha);
		wr(A_CTL, 32'h1);
		wait_idle();
		seq(4, '{18'h00009, 18'h20000, 18'h3000a, 18'h10004});
		axi_rd(A_ST, d, r);
		check(d & 32'h1f, 32'h10);
		axi_rd(A_C3, d, r);
		check(d, 32'h0000000a);
		$display("done: start");
		// Full update, second request refused while busy
		wr(A_PER, 32'h7);
		wr(A_C2, 32'h3);
		wr(A_C3, 32'h8);
		wr(A_C1, 32'h2);
		wr(A_CTL, 32'hf);
		wr(A_CTL, 32'hf);
		wait_idle();
		seq(4, '{18'h00007, 18'h20003, 18'h30008, 18'h10002});
		axi_rd(A_CTL, d, r);
		check(d, 32'h0000000d);
		axi_rd(A_ST, d, r);
		check(d & 32'hc, 32'h4);
		wr(A_ST, 32'h4);
		axi_rd(A_ST, d, r);
		check(d & 32'h4, 32'h0);
		$display("done: full");
		// Period only: channel 1 rewritten unchanged
		wr(A_PER, 32'h5);
		wr(A_CTL, 32'h7);
		wait_idle();
		seq(2, '{18'h00005, 18'h10002, 18'h0, 18'h0});
		check({31'h0, u_timer.need_per_q}, 32'h0);
		// Outputs 2 and 3 only, one at 100 percent
		wr(A_C2, 32'h6);
		wr(A_C3, 32'h1);
		wr(A_CTL, 32'hb);
		wait_idle();
		seq(3, '{18'h20006, 18'h30001, 18'h10002, 18'h0});
		// Output 1 only, to 0 percent
		wr(A_C1, 32'h0);
		wr(A_CTL, 32'h3);
		wait_idle();
		seq(1, '{18'h10000, 18'h0, 18'h0, 18'h0});
		repeat (8) @(posedge aclk);
		check({31'h0, u_timer.pwm_out1}, 32'h0);
		check({31'h0, early_write}, 32'h0);
		$display("done: partial");
		// Width beyond period plus one flagged, then cleared
		wr(A_C2, 32'h7);
		axi_rd(A_ST, d, r);
		check(d & 32'h8, 32'h8);
		wr(A_ST, 32'h8);
		axi_rd(A_ST, d, r);
		check(d & 32'h8, 32'h0);
		// Disable stops counting
		wr(A_CTL, 32'h0);
		@(posedge aclk);
		check({31'h0, count_enable}, 32'h0);
		axi_rd(A_ST, d, r);
		check(d & 32'h10, 32'h0);
		$display("done: range and disable");
		end_sim();
	end
	// Overall hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		failures++;
		end_sim();
	end
endmodule : tb_top

// *** tb/timer_model.sv ***
// Behavioural timer: compare registers, shadow reload, count and match interrupts
`timescale 1ns/1ps
module timer_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Compare register write port
	input wire logic cmp_wr,
	input wire logic [1:0] cmp_sel,
	input wire logic [15:0] cmp_wdata,
	input wire logic count_enable,
	// Match interrupts and misuse flag
	output logic period_match_irq,
	output logic chan1_match_irq,
	output logic early_write
);
	logic [15:0] cmp_q [4];
	logic [15:0] live [4];
	logic [15:0] shd_q [4];
	logic [15:0] cnt_q;
	logic [15:0] nxt;
	logic en_q, armed_q, per_nom_q, c1_nom_q, need_per_q, need_c1_q, sq_q;
	logic pwm_out1;
	// Count wraps at the shadow period; channel 1 active below its shadow
	assign nxt = (cnt_q == shd_q[0]) ? 16'h0000 : cnt_q + 16'h0001;
	assign pwm_out1 = en_q && (cnt_q < shd_q[1]);
	// Register values including a write landing this edge
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			live[i] = (cmp_wr && cmp_sel == 2'(i)) ? cmp_wdata : cmp_q[i];
		end
	end
	// Compare registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_q <= '{default: 16'h0000};
		end else if (cmp_wr) begin
			cmp_q[cmp_sel] <= cmp_wdata;
		end
	end
	// Counter, shadow reload and nominal match events
	always_ff @(posedge aclk) begin
		if (!aresetn || !count_enable) begin
			en_q <= 1'b0;
			cnt_q <= 16'hffff;
			armed_q <= 1'b0;
			per_nom_q <= 1'b0;
			c1_nom_q <= 1'b0;
			sq_q <= 1'b0;
		end else if (!en_q) begin
			en_q <= 1'b1;
			cnt_q <= 16'h0000;
			shd_q <= live;
		end else begin
			cnt_q <= nxt;
			per_nom_q <= (cnt_q == shd_q[0]);
			c1_nom_q <= (nxt == shd_q[1]);
			if (cnt_q == shd_q[0]) begin
				sq_q <= ~sq_q;
				if (armed_q) begin
					shd_q <= live;
					armed_q <= 1'b0;
				end
			end
			// Only a channel 1 write arms the reload
			if (cmp_wr && cmp_sel == 2'h1) armed_q <= 1'b1;
		end
	end
	// Pending update bookkeeping, dropped when counting stops
	always_ff @(posedge aclk) begin
		if (!aresetn || !count_enable) begin
			need_per_q <= 1'b0;
			need_c1_q <= 1'b0;
		end else begin
			if (period_match_irq) need_per_q <= 1'b0;
			if (chan1_match_irq || cmp_q[1] == cmp_q[0] + 16'h0001) need_c1_q <= 1'b0;
			if (cmp_wr && en_q && cmp_sel == 2'h1) begin
				need_per_q <= 1'b1;
				need_c1_q <= 1'b1;
			end
		end
	end
	// Interrupts trail the nominal count edge by one clock; misuse is sticky
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_match_irq <= 1'b0;
			chan1_match_irq <= 1'b0;
			early_write <= 1'b0;
		end else begin
			period_match_irq <= per_nom_q;
			chan1_match_irq <= c1_nom_q;
			if (cmp_wr && en_q && (need_per_q || need_c1_q)) early_write <= 1'b1;
		end
	end
endmodule : timer_model
